/* File: src/tcs_defs.svh */
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// geometry
`define TCS_NCH 6
`define TCS_NIRQ 12
`define TCS_ADDR_W 8
// channels with direction and underflow support (1, 2, 4, 5)
`define TCS_PHASE_CH_MASK 6'h36

// register byte offsets: channel n at base + n * stride
`define TCS_STATUS_BASE 8'h00
`define TCS_ENABLE_BASE 8'h04
`define TCS_CH_STRIDE 8'h08
`define TCS_IRQ_STATUS 8'h30
`define TCS_IRQ_MASK 8'h34

// channel_status bit positions
`define TCS_BIT_DIR 7
`define TCS_BIT_RSV6 6
`define TCS_BIT_UNF 5
`define TCS_BIT_OVF 4
`define TCS_BIT_FB 1
`define TCS_BIT_FA 0
// enable register bit positions
`define TCS_BIT_IEB 1
`define TCS_BIT_IEA 0
// irq_status layout: overflow events low, underflow events above
`define TCS_IRQ_UNF_LSB 6

// reset value of the direction flags, and fixed read values of reserved bits
`define TCS_DIR_RESET 6'h3F
`define TCS_RSV_ONE 1'b1
`define TCS_RSV_ZERO 1'b0

`endif

/* File: src/tcs_pkg.sv */
`include "tcs_defs.svh"

package tcs_pkg;

  typedef logic [`TCS_NCH-1:0] tcs_chv_type;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    tcs_chv_type dir;
    tcs_chv_type unf;
    tcs_chv_type ovf;
    tcs_chv_type fa;
    tcs_chv_type fb;
    tcs_chv_type arm_unf;
    tcs_chv_type arm_ovf;
    tcs_chv_type arm_fa;
    tcs_chv_type arm_fb;
    tcs_chv_type ien_a;
    tcs_chv_type ien_b;
    tcs_chv_type req_a;
    tcs_chv_type req_b;
    logic [`TCS_NIRQ-1:0] ist;
    logic [`TCS_NIRQ-1:0] imask;
    logic irq;
  } tcs_state_type;

endpackage : tcs_pkg

/* File: src/tcs_top.sv */
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "tcs_defs.svh"

module tcs_top
  import tcs_pkg::*;
#(
  parameter int NCH = `TCS_NCH
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TCS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NCH-1:0] overflow_event,
  input wire logic [NCH-1:0] underflow_event,
  input wire logic [NCH-1:0] phase_mode,
  input wire logic [NCH-1:0] count_up,
  input wire logic [NCH-1:0] match_event_a,
  input wire logic [NCH-1:0] match_event_b,
  output logic [NCH-1:0] irq_request_a,
  output logic [NCH-1:0] irq_request_b,
  output logic irq
);

  if (NCH != `TCS_NCH)
  begin : g_nch_check
    $error("tcs_top: channel count must be six");
  end

  localparam logic [NCH-1:0] PHASE_CH = `TCS_PHASE_CH_MASK;

  tcs_state_type st_reg;
  tcs_state_type st_next;

  // a request is taken in two steps: accept, then complete
  logic bus_req;
  logic bus_done;
  logic rd_done;
  logic wr_done;
  logic wr_lane0;

  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~st_reg.waitrequest;
  assign rd_done = avs_read & ~st_reg.waitrequest;
  assign wr_done = avs_write & ~st_reg.waitrequest;
  assign wr_lane0 = wr_done & avs_byteenable[0];

  function automatic logic [7:0] status_byte(
    input tcs_state_type s,
    input int ch
  );
    logic [7:0] v;
    v = 8'h00;
    // reserved direction bit reads 1 outside phase channels
    v[`TCS_BIT_DIR] = PHASE_CH[ch] ? s.dir[ch] : `TCS_RSV_ONE;
    v[`TCS_BIT_RSV6] = `TCS_RSV_ONE;
    v[`TCS_BIT_UNF] = PHASE_CH[ch] ? s.unf[ch] : `TCS_RSV_ZERO;
    v[`TCS_BIT_OVF] = s.ovf[ch];
    v[`TCS_BIT_FB] = s.fb[ch];
    v[`TCS_BIT_FA] = s.fa[ch];
    return v;
  endfunction : status_byte

  always_comb
  begin
    logic [7:0] sel_status;
    logic [7:0] sel_enable;
    logic [`TCS_NIRQ-1:0] ev;
    logic [`TCS_NIRQ-1:0] ist_clr;
    logic hit_s;
    logic hit_e;
    logic set_u;
    logic set_v;
    logic clr_u;
    logic clr_v;
    logic clr_a;
    logic clr_b;
    logic [31:0] rdv;
    sel_status = 8'h00;
    sel_enable = 8'h00;
    ev = '0;
    ist_clr = '0;
    hit_s = 1'b0;
    hit_e = 1'b0;
    set_u = 1'b0;
    set_v = 1'b0;
    clr_u = 1'b0;
    clr_v = 1'b0;
    clr_a = 1'b0;
    clr_b = 1'b0;
    rdv = 32'h0000_0000;
    st_next = st_reg;

    for (int ch = 0; ch < NCH; ch++)
    begin
      hit_s = (avs_address == 8'(`TCS_STATUS_BASE
        + ch * `TCS_CH_STRIDE));
      hit_e = (avs_address == 8'(`TCS_ENABLE_BASE
        + ch * `TCS_CH_STRIDE));
      if (hit_s)
      begin
        sel_status = status_byte(st_reg, ch);
      end
      if (hit_e)
      begin
        sel_enable[`TCS_BIT_IEB] = st_reg.ien_b[ch];
        sel_enable[`TCS_BIT_IEA] = st_reg.ien_a[ch];
      end

      if (PHASE_CH[ch])
      begin
        st_next.dir[ch] = count_up[ch];
      end

      set_u = PHASE_CH[ch] & phase_mode[ch] & underflow_event[ch];
      set_v = overflow_event[ch];
      ev[ch] = set_v;
      ev[`TCS_IRQ_UNF_LSB + ch] = set_u;

      // arm from the byte handed back, not the live flag: a flag set
      // during the wait cycle was never seen at 1 by software
      if (rd_done && hit_s)
      begin
        st_next.arm_unf[ch] = st_reg.readdata[`TCS_BIT_UNF];
        st_next.arm_ovf[ch] = st_reg.readdata[`TCS_BIT_OVF];
        st_next.arm_fa[ch] = st_reg.readdata[`TCS_BIT_FA];
        st_next.arm_fb[ch] = st_reg.readdata[`TCS_BIT_FB];
      end

      clr_u = wr_lane0 & hit_s & st_reg.arm_unf[ch]
        & ~avs_writedata[`TCS_BIT_UNF];
      clr_v = wr_lane0 & hit_s & st_reg.arm_ovf[ch]
        & ~avs_writedata[`TCS_BIT_OVF];
      clr_a = wr_lane0 & hit_s & st_reg.arm_fa[ch]
        & ~avs_writedata[`TCS_BIT_FA];
      clr_b = wr_lane0 & hit_s & st_reg.arm_fb[ch]
        & ~avs_writedata[`TCS_BIT_FB];

      // a set in the clearing cycle wins over the clear
      st_next.unf[ch] = set_u | (st_reg.unf[ch] & ~clr_u);
      st_next.ovf[ch] = set_v | (st_reg.ovf[ch] & ~clr_v);
      st_next.fa[ch] = match_event_a[ch] | (st_reg.fa[ch] & ~clr_a);
      st_next.fb[ch] = match_event_b[ch]
        | (st_reg.fb[ch] & ~clr_b);

      if (clr_u)
      begin
        st_next.arm_unf[ch] = 1'b0;
      end
      if (clr_v)
      begin
        st_next.arm_ovf[ch] = 1'b0;
      end
      if (clr_a)
      begin
        st_next.arm_fa[ch] = 1'b0;
      end
      if (clr_b)
      begin
        st_next.arm_fb[ch] = 1'b0;
      end

      if (wr_lane0 && hit_e)
      begin
        st_next.ien_b[ch] = avs_writedata[`TCS_BIT_IEB];
        st_next.ien_a[ch] = avs_writedata[`TCS_BIT_IEA];
      end
    end

    // requests follow the next flag and enable so they stay levels
    st_next.req_a = st_next.fa & st_next.ien_a;
    st_next.req_b = st_next.fb & st_next.ien_b;

    if (wr_done && avs_address == `TCS_IRQ_STATUS)
    begin
      ist_clr = avs_writedata[`TCS_NIRQ-1:0];
    end
    if (wr_done && avs_address == `TCS_IRQ_MASK)
    begin
      st_next.imask = avs_writedata[`TCS_NIRQ-1:0];
    end
    st_next.ist = ev | (st_reg.ist & ~ist_clr);
    st_next.irq = |(st_next.ist & st_next.imask);

    rdv[7:0] = sel_status | sel_enable;
    if (avs_address == `TCS_IRQ_STATUS)
    begin
      rdv[`TCS_NIRQ-1:0] = st_reg.ist;
    end
    if (avs_address == `TCS_IRQ_MASK)
    begin
      rdv[`TCS_NIRQ-1:0] = st_reg.imask;
    end

    // one wait cycle: data is latched on accept, stands while low
    if (bus_done)
    begin
      st_next.waitrequest = 1'b1;
    end
    else if (bus_req)
    begin
      st_next.waitrequest = 1'b0;
      st_next.readdata = avs_read ? rdv : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.waitrequest <= 1'b1;
      st_reg.dir <= `TCS_DIR_RESET;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = st_reg.readdata;
  assign avs_waitrequest = st_reg.waitrequest;
  assign irq_request_a = st_reg.req_a;
  assign irq_request_b = st_reg.req_b;
  assign irq = st_reg.irq;

  logic rd_s0;
  logic rd_s1;
  assign rd_s0 = rd_done && avs_address == `TCS_STATUS_BASE;
  assign rd_s1 = rd_done && avs_address == 8'(`TCS_STATUS_BASE
    + `TCS_CH_STRIDE);
  logic rd_s3;
  assign rd_s3 = rd_done && avs_address == 8'(`TCS_STATUS_BASE
    + 3 * `TCS_CH_STRIDE);

  AST_REQ_B: assert property (
    @(posedge mclk) disable iff (rst)
    irq_request_b == (st_reg.fb & st_reg.ien_b))
  else $error("request b differs from flag and enable");

  AST_REQ_A: assert property (
    @(posedge mclk) disable iff (rst)
    irq_request_a == (st_reg.fa & st_reg.ien_a))
  else $error("request a differs from flag and enable");

  AST_DIR_TRACK: assert property (
    @(posedge mclk) disable iff (rst)
    ce |=> st_reg.dir[1] == $past(count_up[1])
      && st_reg.dir[5] == $past(count_up[5]))
  else $error("direction flag does not follow count direction");

  AST_RSV_DIR: assert property (
    @(posedge mclk) disable iff (rst)
    rd_s0 |-> avs_readdata[`TCS_BIT_DIR] == 1'b1)
  else $error("reserved direction bit did not read one");

  AST_RSV6: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_s0 || rd_s1) |-> avs_readdata[`TCS_BIT_RSV6] == 1'b1)
  else $error("bit six did not read one");

  AST_UNF_SET: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && underflow_event[1] && phase_mode[1]) |=> st_reg.unf[1])
  else $error("underflow event did not set the flag");

  AST_UNF_HOLD: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && !wr_done) |=> (st_reg.unf & $past(st_reg.unf))
      == $past(st_reg.unf))
  else $error("underflow flag fell without a write");

  AST_RSV_UNF: assert property (
    @(posedge mclk) disable iff (rst)
    rd_s0 |-> avs_readdata[`TCS_BIT_UNF] == 1'b0)
  else $error("reserved underflow bit did not read zero");

  AST_OVF_SET: assert property (
    @(posedge mclk) disable iff (rst)
    ce && |overflow_event |=> (st_reg.ovf & $past(overflow_event))
      == $past(overflow_event))
  else $error("overflow event did not set the flag");

  AST_OVF_HOLD: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && !wr_done) |=> (st_reg.ovf & $past(st_reg.ovf))
      == $past(st_reg.ovf))
  else $error("overflow flag fell without a write");

  AST_FB_SET: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && match_event_b[0]) |=> st_reg.fb[0])
  else $error("match event b did not set flag b");

  AST_REQ_LEVEL: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && irq_request_a[0] && !wr_done) |=> irq_request_a[0])
  else $error("request a dropped without a write");

  AST_RSV_CH3: assert property (
    @(posedge mclk) disable iff (rst)
    rd_s3 |-> avs_readdata[`TCS_BIT_DIR] == 1'b1
      && avs_readdata[`TCS_BIT_UNF] == 1'b0)
  else $error("reserved bits of channel three read wrong");

  AST_UNF_WR1: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && wr_done && avs_writedata[`TCS_BIT_UNF]) |=>
      (st_reg.unf & $past(st_reg.unf)) == $past(st_reg.unf))
  else $error("writing one cleared an underflow flag");

  AST_OVF_WR1: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && wr_done && avs_writedata[`TCS_BIT_OVF]) |=>
      (st_reg.ovf & $past(st_reg.ovf)) == $past(st_reg.ovf))
  else $error("writing one cleared an overflow flag");

  AST_RST_VALUES: assert property (
    @(posedge mclk) disable iff (rst)
    $fell(rst) |-> st_reg.dir == `TCS_DIR_RESET && st_reg.unf == '0
      && st_reg.ovf == '0 && !irq)
  else $error("state after reset differs from reset values");

  AST_BUS_ANSWER: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && bus_req && avs_waitrequest) |=> !avs_waitrequest)
  else $error("bus request not answered after one wait cycle");

endmodule : tcs_top

/* File: sim/tcs_cnt_model.sv */
`timescale 1ns/1ps

module tcs_cnt_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic step,
  input wire logic up,
  output logic wrap_up,
  output logic wrap_down
);
  logic [15:0] cnt_reg;

  // wrap pulses are registered so they land as one-cycle events
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_reg <= 16'h0000;
      wrap_up <= 1'b0;
      wrap_down <= 1'b0;
    end
    else
    begin
      wrap_up <= step && up && cnt_reg == 16'hFFFF;
      wrap_down <= step && !up && cnt_reg == 16'h0000;
      if (step)
        cnt_reg <= up ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
    end
  end
endmodule : tcs_cnt_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
`include "tcs_defs.svh"

module tb;
  import tcs_pkg::*;
  logic mclk, rst, ce, avs_read, avs_write, avs_waitrequest, irq;
  logic step, up, wu, wd;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [5:0] phase_mode, count_up, ma, mb, ra, rb;
  logic [5:0] pm = `TCS_PHASE_CH_MASK;
  int err_count, compares;

  tcs_top DUT (.mclk(mclk), .rst(rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .overflow_event({6{wu}}),
    .underflow_event({6{wd}}), .phase_mode(phase_mode),
    .count_up(count_up), .match_event_a(ma), .match_event_b(mb),
    .irq_request_a(ra), .irq_request_b(rb), .irq(irq));

  tcs_cnt_model u_cnt (.mclk(mclk), .rst(rst), .step(step), .up(up),
    .wrap_up(wu), .wrap_down(wd));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task finish_test;
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // an edge always passes before a new request, so strobes never glitch
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      err_count++;
      finish_test();
    end
  endtask : bus

  task pulse(input logic dir_up);
    @(posedge mclk);
    up <= dir_up;
    step <= 1'b1;
    @(posedge mclk);
    step <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : pulse

  function automatic logic [7:0] sta(input int c);
    return 8'(`TCS_STATUS_BASE + c * `TCS_CH_STRIDE);
  endfunction : sta

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    step = 1'b0;
    up = 1'b0;
    phase_mode = 6'h00;
    count_up = 6'h3F;
    ma = 6'h00;
    mb = 6'h00;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, sta(i), 32'h0000_0000, rd);
      check(rd, 32'h0000_00C0);
    end
    // ones written to flags and reserved bits must not stick
    bus(1'b1, sta(1), 32'h0000_00FF, rd);
    count_up <= 6'h00;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, sta(i), 32'h0000_0000, rd);
      check(rd, pm[i] ? 32'h0000_0040 : 32'h0000_00C0);
    end
    phase_mode <= 6'h3F;
    pulse(1'b0);
    pulse(1'b1);
    // zero written without a prior read of one must not clear
    bus(1'b1, sta(2), 32'h0000_0000, rd);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, sta(i), 32'h0000_0000, rd);
      check(rd, pm[i] ? 32'h0000_0070 : 32'h0000_00D0);
    end
    bus(1'b1, sta(2), 32'h0000_0000, rd);
    bus(1'b0, sta(2), 32'h0000_0000, rd);
    check(rd, 32'h0000_0040);
    // channel 1 is armed by the read above; ones must leave its flags
    bus(1'b1, sta(1), 32'h0000_0030, rd);
    bus(1'b0, sta(1), 32'h0000_0000, rd);
    check(rd, 32'h0000_0070);
    bus(1'b0, 8'h30, 32'h0000_0000, rd);
    check(rd, 32'h0000_0DBF);
    check({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, 8'h34, 32'h0000_0001, rd);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, 8'h30, 32'h0000_0001, rd);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0000_0000);
    @(posedge mclk);
    ma <= 6'h01;
    mb <= 6'h01;
    @(posedge mclk);
    ma <= 6'h00;
    mb <= 6'h00;
    repeat (2) @(posedge mclk);
    check({20'h0, ra, rb}, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0000_0001, rd);
    repeat (2) @(posedge mclk);
    check({20'h0, ra, rb}, 32'h0000_0040);
    bus(1'b1, 8'h04, 32'h0000_0002, rd);
    repeat (2) @(posedge mclk);
    check({20'h0, ra, rb}, 32'h0000_0001);
    bus(1'b0, sta(0), 32'h0000_0000, rd);
    check(rd, 32'h0000_00D3);
    bus(1'b1, sta(0), 32'h0000_0000, rd);
    repeat (2) @(posedge mclk);
    check({20'h0, ra, rb}, 32'h0000_0000);
    bus(1'b0, 8'hFC, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    // wraps below must not land: phase mode off, then clock enable low
    bus(1'b1, 8'h30, 32'h0000_0FFF, rd);
    phase_mode <= 6'h00;
    pulse(1'b0);
    ce <= 1'b0;
    pulse(1'b1);
    ce <= 1'b1;
    bus(1'b0, 8'h30, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    finish_test();
  end
endmodule : tb
